// file: exz_pkg.sv
// Package for the E1 receive excessive-zero / Sa7 / signalling interrupt block
package exz_pkg;

	// Register offsets (index on the plain register port)
	localparam logic [3:0] EXZ_ADDR_ZERO_EN = 4'h0;
	localparam logic [3:0] EXZ_ADDR_ZERO_STAT = 4'h1;
	localparam logic [3:0] EXZ_ADDR_SIG_STAT = 4'h2;
	localparam logic [3:0] EXZ_ADDR_SIG_EN = 4'h3;

	// Bit positions of the zero/Sa7 registers
	localparam int EXZ_BIT_EXZ = 0;
	localparam int EXZ_BIT_SA7 = 1;
	localparam int EXZ_BIT_SA7_STATE = 5;

	// Bit positions of the signalling registers
	localparam int EXZ_BIT_OVL = 0;
	localparam int EXZ_BIT_FAIL = 1;
	localparam int EXZ_BIT_RX_EOT = 2;
	localparam int EXZ_BIT_TX_EOT = 3;
	localparam int EXZ_BIT_RX_SOT = 4;
	localparam int EXZ_BIT_TX_SOT = 5;

	// Writable masks and reset values
	localparam logic [7:0] EXZ_ZERO_EN_MASK = 8'h03;
	localparam logic [7:0] EXZ_SIG_EN_MASK = 8'h3f;
	localparam logic [7:0] EXZ_REG_RESET = 8'h00;

	// Over-length message limit in bytes and CRC thresholds in frames
	localparam int EXZ_MSG_MAX_BYTES = 276;
	localparam int EXZ_CRC_THR_LO = 32;
	localparam int EXZ_CRC_THR_HI = 64;

	// Sa7 vote: zero in at least two of three samples; history idles at ones
	localparam logic [1:0] EXZ_SA7_VOTE_MIN = 2'h2;
	localparam logic [1:0] EXZ_SA7_HIST_IDLE = 2'h3;

	// Register port
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} exz_bus_t;

	// Per-frame events from the receive and transmit datapaths
	typedef struct packed {
		logic frame_tick;
		logic sa7_bit;
		logic exz_state;
		logic sig_frame_end;
		logic sig_crc_bad;
		logic sig_byte;
		logic sig_msg_start;
		logic tx_start;
		logic tx_end;
		logic rx_start;
		logic rx_end;
	} exz_evt_t;

	// Sa7 vote states
	typedef enum logic [1:0] {
		EXZ_SA7_CLEAR = 2'b01,
		EXZ_SA7_ZERO = 2'b10
	} exz_sa7_t;

endpackage

// file: exz_crc_count.sv
// Consecutive bad-CRC frame counter raising a one-cycle failure pulse
`timescale 1ns/100ps
module exz_crc_count
	import exz_pkg::*;
#(
	parameter int CNT_W = 7
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Frame results
	input wire logic frame_end,
	input wire logic crc_bad,
	input wire logic thr_sel,
	// Threshold reached
	output logic fail_pulse
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic fail;
	} exz_cnt_st_t;

	exz_cnt_st_t s_q;
	exz_cnt_st_t s_d;
	logic [CNT_W-1:0] thr;

	always_comb begin
		s_d = s_q;
		s_d.fail = 1'b0;
		thr = thr_sel ? CNT_W'(EXZ_CRC_THR_HI) : CNT_W'(EXZ_CRC_THR_LO);
		if (frame_end) begin
			if (!crc_bad) begin
				s_d.cnt = '0;
			end else if (s_q.cnt + CNT_W'(1) == thr) begin
				// Restart so a long bad run reports once per threshold
				s_d.cnt = '0;
				s_d.fail = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fail_pulse = s_q.fail;
endmodule // exz_crc_count

// file: exz_irq.sv
// E1 receive excessive-zero, Sa7 and signalling interrupt controller
`timescale 1ns/100ps
module exz_irq
	import exz_pkg::*;
#(
	parameter int LEN_W = 9
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire exz_pkg::exz_bus_t bus,
	output logic [7:0] rdata,
	// Datapath events
	input wire exz_pkg::exz_evt_t evt,
	input wire logic crc_thr_sel,
	// Interrupt
	output logic irq
);
	import exz_pkg::*;

	typedef struct packed {
		logic [7:0] zero_en;
		logic [7:0] zero_stat;
		logic [7:0] sig_en;
		logic [7:0] sig_stat;
		logic [1:0] sa7_hist;
		exz_sa7_t sa7_st;
		logic exz_prev;
		logic [LEN_W-1:0] msg_len;
		logic ovl_seen;
		logic [7:0] rdata;
		logic irq;
	} exz_st_t;

	exz_st_t s_q;
	exz_st_t s_d;
	logic fail_pulse;
	logic [1:0] votes;
	logic sa7_change;
	logic exz_change;
	logic ovl_evt;
	logic [7:0] zero_set;
	logic [7:0] sig_set;

	exz_crc_count #(
		.CNT_W(7)
	) u_crc (
		.clock(clock),
		.rst_n(rst_n),
		.frame_end(evt.sig_frame_end),
		.crc_bad(evt.sig_crc_bad),
		.thr_sel(crc_thr_sel),
		.fail_pulse(fail_pulse)
	);

	always_comb begin
		s_d = s_q;
		sa7_change = 1'b0;
		ovl_evt = 1'b0;
		votes = 2'd0;
		// Sa7 vote over the current and two previous observations
		if (evt.frame_tick) begin
			votes = 2'(!evt.sa7_bit) + 2'(!s_q.sa7_hist[0]) + 2'(!s_q.sa7_hist[1]);
			s_d.sa7_hist = {s_q.sa7_hist[0], evt.sa7_bit};
			case (s_q.sa7_st)
				EXZ_SA7_CLEAR: begin
					if (votes >= EXZ_SA7_VOTE_MIN) begin
						s_d.sa7_st = EXZ_SA7_ZERO;
						sa7_change = 1'b1;
					end
				end
				EXZ_SA7_ZERO: begin
					if (votes < EXZ_SA7_VOTE_MIN) begin
						s_d.sa7_st = EXZ_SA7_CLEAR;
						sa7_change = 1'b1;
					end
				end
				default: begin
					s_d.sa7_st = EXZ_SA7_CLEAR;
				end
			endcase
		end
		// Both edges of excessive-zero count as a change
		exz_change = evt.exz_state != s_q.exz_prev;
		s_d.exz_prev = evt.exz_state;
		// Message length, counting bytes; flag once per message
		if (evt.sig_msg_start) begin
			s_d.msg_len = '0;
			s_d.ovl_seen = 1'b0;
		end else if (evt.sig_byte) begin
			if (s_q.msg_len == LEN_W'(EXZ_MSG_MAX_BYTES) && !s_q.ovl_seen) begin
				ovl_evt = 1'b1;
				s_d.ovl_seen = 1'b1;
			end else if (s_q.msg_len != LEN_W'(EXZ_MSG_MAX_BYTES)) begin
				s_d.msg_len = s_q.msg_len + LEN_W'(1);
			end
		end
		zero_set = '0;
		zero_set[EXZ_BIT_EXZ] = exz_change;
		zero_set[EXZ_BIT_SA7] = sa7_change;
		sig_set = '0;
		sig_set[EXZ_BIT_OVL] = ovl_evt;
		sig_set[EXZ_BIT_FAIL] = fail_pulse;
		sig_set[EXZ_BIT_RX_EOT] = evt.rx_end;
		sig_set[EXZ_BIT_TX_EOT] = evt.tx_end;
		sig_set[EXZ_BIT_RX_SOT] = evt.rx_start;
		sig_set[EXZ_BIT_TX_SOT] = evt.tx_start;
		// Register writes; reserved bits never stored
		if (bus.wr && bus.addr == EXZ_ADDR_ZERO_EN) begin
			s_d.zero_en = bus.wdata & EXZ_ZERO_EN_MASK;
		end
		if (bus.wr && bus.addr == EXZ_ADDR_SIG_EN) begin
			s_d.sig_en = bus.wdata & EXZ_SIG_EN_MASK;
		end
		// Reads; status registers clear on read, a same-cycle event survives
		s_d.rdata = '0;
		s_d.zero_stat = s_q.zero_stat;
		s_d.sig_stat = s_q.sig_stat;
		if (bus.rd) begin
			case (bus.addr)
				EXZ_ADDR_ZERO_EN: begin
					s_d.rdata = s_q.zero_en;
				end
				EXZ_ADDR_ZERO_STAT: begin
					s_d.rdata = s_q.zero_stat;
					s_d.rdata[EXZ_BIT_SA7_STATE] = (s_q.sa7_st == EXZ_SA7_ZERO);
					s_d.zero_stat = '0;
				end
				EXZ_ADDR_SIG_STAT: begin
					s_d.rdata = s_q.sig_stat;
					s_d.sig_stat = '0;
				end
				EXZ_ADDR_SIG_EN: begin
					s_d.rdata = s_q.sig_en;
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
		// Status bits latch regardless of enable; enable gates the pin only
		s_d.zero_stat = s_d.zero_stat | zero_set;
		s_d.sig_stat = s_d.sig_stat | sig_set;
		s_d.irq = |(s_d.zero_stat & s_d.zero_en) | |(s_d.sig_stat & s_d.sig_en);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q.zero_en <= EXZ_REG_RESET;
			s_q.zero_stat <= EXZ_REG_RESET;
			s_q.sig_en <= EXZ_REG_RESET;
			s_q.sig_stat <= EXZ_REG_RESET;
			s_q.sa7_hist <= EXZ_SA7_HIST_IDLE;
			s_q.sa7_st <= EXZ_SA7_CLEAR;
			s_q.exz_prev <= 1'b0;
			s_q.msg_len <= '0;
			s_q.ovl_seen <= 1'b0;
			s_q.rdata <= '0;
			s_q.irq <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign irq = s_q.irq;
endmodule // exz_irq

// file: exz_irq_monitor.sv
// Checker for the excessive-zero, Sa7 and signalling interrupt block
`timescale 1ns/100ps
module exz_irq_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire exz_pkg::exz_bus_t bus,
	input wire logic [7:0] rdata,
	// Events and interrupt
	input wire exz_pkg::exz_evt_t evt,
	input wire logic crc_thr_sel,
	input wire logic irq
);
	import exz_pkg::*;
	logic [7:0] zen_q;
	logic [7:0] sen_q;
	logic xfer;
	assign xfer = evt.tx_start | evt.tx_end | evt.rx_start | evt.rx_end;
	// Shadow enables, so irq can be judged without peeking inside
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			zen_q <= 8'h00;
			sen_q <= 8'h00;
		end else if (bus.wr && bus.addr == EXZ_ADDR_ZERO_EN) begin
			zen_q <= bus.wdata & EXZ_ZERO_EN_MASK;
		end else if (bus.wr && bus.addr == EXZ_ADDR_SIG_EN) begin
			sen_q <= bus.wdata & EXZ_SIG_EN_MASK;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_zero_en_read: assert property (
		bus.rd && bus.addr == EXZ_ADDR_ZERO_EN |=> rdata == zen_q) else $error("zero enable");
	a_sig_en_read: assert property (
		bus.rd && bus.addr == EXZ_ADDR_SIG_EN |=> rdata == sen_q) else $error("sig enable");
	a_sig_rsv_zero: assert property (
		bus.rd && bus.addr == EXZ_ADDR_SIG_STAT |=> rdata[7:6] == 2'b00) else $error("reserved");
	a_sig_evt_latch: assert property (
		bus.rd && bus.addr == EXZ_ADDR_SIG_STAT && $past(evt.rx_end) |=> rdata[EXZ_BIT_RX_EOT])
		else $error("rx end lost");
	a_sig_rd_clear: assert property (
		bus.rd && bus.addr == EXZ_ADDR_SIG_STAT && !xfer ##1 !xfer ##1
		bus.rd && bus.addr == EXZ_ADDR_SIG_STAT |=> rdata[5:2] == 4'h0) else $error("no clear");
	a_exz_change_irq: assert property (
		zen_q[EXZ_BIT_EXZ] && !bus.wr && evt.exz_state != $past(evt.exz_state) |=> irq)
		else $error("exz irq missing");
	a_irq_masked: assert property (
		zen_q == 8'h00 && sen_q == 8'h00 && !bus.wr |=> !irq) else $error("irq while masked");
	a_sig_en_irq: assert property (
		sen_q[EXZ_BIT_RX_EOT] && evt.rx_end && !bus.wr |=> irq) else $error("rx end irq missing");
endmodule // exz_irq_monitor

bind exz_irq exz_irq_monitor u_exz_irq_monitor (.clock(clock), .rst_n(rst_n), .bus(bus),
	.rdata(rdata), .evt(evt), .crc_thr_sel(crc_thr_sel), .irq(irq));

// file: test_exz_irq.sv
// Self-checking bench for the excessive-zero, Sa7 and signalling interrupt block
`timescale 1ns/100ps
module test_exz_irq;
	import exz_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic crc_thr_sel = 1'b0;
	logic exz_lvl = 1'b0;
	logic [10:0] ev = 11'h000;
	exz_bus_t bus = '0;
	logic [7:0] rdata;
	logic irq;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	// Address, write data, read-back
	logic [19:0] rows [6] = '{20'h0ff03, 20'h3ff3f, 20'h9ff00, 20'hfff00, 20'h00000, 20'h30000};
	exz_irq u_exz_irq (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.evt(ev | {2'b00, exz_lvl, 8'h00}), .crc_thr_sel(crc_thr_sel), .irq(irq));
	always #20 clock = ~clock;
	task automatic end_sim();
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Runs are under 1500 cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		bus <= '0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		bus <= '0;
		#1 chk(rdata, exp);
	endtask
	task automatic pulse(input logic [10:0] v);
		@(posedge clock);
		ev <= v;
		@(posedge clock);
		ev <= 11'h000;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) rdc(i[3:0], 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][19:16], rows[i][15:8]);
			rdc(rows[i][19:16], rows[i][7:0]);
		end
		@(posedge clock) exz_lvl <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk({7'h00, irq}, 8'h00);
		rdc(4'h1, 8'h01);
		rdc(4'h1, 8'h00);
		wr(4'h0, 8'h03);
		@(posedge clock) exz_lvl <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({7'h00, irq}, 8'h01);
		rdc(4'h1, 8'h01);
		pulse(11'h400);
		pulse(11'h400);
		#1 chk({7'h00, irq}, 8'h01);
		rdc(4'h1, 8'h22);
		pulse(11'h600);
		pulse(11'h600);
		rdc(4'h1, 8'h02);
		pulse(11'h400);
		rdc(4'h1, 8'h00);
		wr(4'h0, 8'h01);
		pulse(11'h400);
		#1 chk({7'h00, irq}, 8'h00);
		rdc(4'h1, 8'h22);
		wr(4'h3, 8'h3c);
		pulse(11'h00f);
		#1 chk({7'h00, irq}, 8'h01);
		rdc(4'h2, 8'h3c);
		rdc(4'h2, 8'h00);
		// Event in the cycle of a clearing read survives it
		@(posedge clock) begin
			ev <= 11'h001;
			bus <= '{4'h2, 8'h00, 1'b0, 1'b1};
		end
		@(posedge clock) ev <= 11'h000;
		#1 chk(rdata, 8'h00);
		@(posedge clock) bus <= '0;
		#1 chk(rdata, 8'h04);
		rdc(4'h2, 8'h00);
		wr(4'h3, 8'h02);
		pulse(11'h010);
		repeat (276) pulse(11'h020);
		rdc(4'h2, 8'h00);
		pulse(11'h020);
		#1 chk({7'h00, irq}, 8'h00);
		wr(4'h3, 8'h03);
		#1 chk({7'h00, irq}, 8'h01);
		rdc(4'h2, 8'h01);
		// Only one over-length report per message
		pulse(11'h020);
		rdc(4'h2, 8'h00);
		// A good frame must restart the consecutive count
		repeat (31) pulse(11'h0c0);
		pulse(11'h080);
		repeat (31) pulse(11'h0c0);
		rdc(4'h2, 8'h00);
		pulse(11'h0c0);
		@(posedge clock);
		#1 chk({7'h00, irq}, 8'h01);
		rdc(4'h2, 8'h02);
		@(posedge clock) crc_thr_sel <= 1'b1;
		wr(4'h3, 8'h01);
		repeat (63) pulse(11'h0c0);
		rdc(4'h2, 8'h00);
		pulse(11'h0c0);
		@(posedge clock);
		#1 chk({7'h00, irq}, 8'h00);
		rdc(4'h2, 8'h02);
		// Reset in mid-run with enables and a status bit set
		pulse(11'h001);
		@(posedge clock) rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		#1 chk({7'h00, irq}, 8'h00);
		for (int i = 0; i < 4; i++) rdc(i[3:0], 8'h00);
		end_sim();
	end
endmodule // test_exz_irq
